//--- include/otl_pkg.sv
// shared constants, types and register map of the over-travel stop logic
`default_nettype none
package otl_pkg;

	// apb register map (byte addresses)
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  OFS_INPUT_ASSIGN = 8'h00;
	localparam logic [7:0]  OFS_STOP_SELECT  = 8'h04;
	localparam logic [7:0]  OFS_BRAKE_TORQUE = 8'h08;
	localparam logic [7:0]  OFS_STATUS       = 8'h0C;

	// field positions: one hex digit each, as in the parameter words
	localparam int          FLD_LOW_LSB     = 8;
	localparam int          FLD_HIGH_LSB    = 12;
	localparam int          FLD_W           = 4;
	localparam int          TRQ_W           = 9;

	// selector codes
	localparam logic [3:0]  SEL_IGNORE      = 4'h9;
	localparam logic [3:0]  FWD_SEL_RESET   = 4'h3;
	localparam logic [3:0]  REV_SEL_RESET   = 4'h4;
	localparam logic [3:0]  STOP_BRAKE      = 4'h0;
	localparam logic [3:0]  LOW_COAST       = 4'h1;
	localparam logic [3:0]  HIGH_CLAMP      = 4'h1;
	localparam logic [3:0]  HIGH_COAST      = 4'h2;

	// braking torque limit in percent of rated torque
	localparam logic [8:0]  TORQUE_MAX      = 9'h12C;

	// status word bit positions
	localparam int          ST_OT_FWD_BIT   = 0;
	localparam int          ST_OT_REV_BIT   = 1;
	localparam int          ST_STATE_LSB    = 2;
	localparam int          ST_CLR_BIT      = 4;
	localparam int          ST_PWR_BIT      = 5;

	typedef enum logic [1:0] {
		MODE_SPEED,
		MODE_POSITION,
		MODE_TORQUE,
		MODE_OTHER
	} ctrl_mode_e;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_BRAKE,
		ST_COAST,
		ST_CLAMP
	} ot_state_e;

	typedef struct packed {
		logic [3:0] fwdSel;
		logic [3:0] revSel;
		logic [3:0] lowSel;
		logic [3:0] highSel;
	} ot_cfg_s;

	localparam ot_cfg_s CFG_RESET = '{fwdSel: FWD_SEL_RESET, revSel: REV_SEL_RESET,
		lowSel: STOP_BRAKE, highSel: STOP_BRAKE};

endpackage
`default_nettype wire

//--- core/sync_2ff.sv
// two-stage synchroniser for a group of level inputs
`default_nettype none
module sync_2ff #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,   // destination clock
	input  wire logic             rst,   // synchronous reset, active high
	input  wire logic [WIDTH-1:0] d,     // asynchronous levels
	output var  logic [WIDTH-1:0] q      // synchronised levels
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule
`default_nettype wire

//--- core/overtravel_limit_stop_logic.sv
// over-travel limit detection and stop sequencing for one axis, apb configured
`default_nettype none
module overtravel_limit_stop_logic
	import otl_pkg::*;
#(
	parameter int NUM_INPUTS = 8
) (
	input  wire logic                  clk,                // drive clock, 250 MHz
	input  wire logic                  rst,                // synchronous reset, active high
	input  wire logic [NUM_INPUTS-1:0] genIn,              // general inputs, index 0 is input 1
	input  wire logic                  cmdFwd,             // motion requested forward
	input  wire logic                  cmdRev,             // motion requested reverse
	input  wire logic                  standstill,         // motor speed at zero
	input  wire logic                  servoOn,            // servo on command, active high
	input  wire ctrl_mode_e            ctrlMode,           // active control mode
	input  wire logic                  positionErrorClear, // host clears position offset
	input  wire logic                  powerCycle,         // restart pulse, loads settings
	input  wire logic                  psel,               // apb select
	input  wire logic                  penable,            // apb enable
	input  wire logic                  pwrite,             // apb write
	input  wire logic [ADDR_W-1:0]     paddr,              // apb byte address
	input  wire logic [31:0]           pwdata,             // apb write data
	output var  logic [31:0]           prdata,             // apb read data
	output var  logic                  pready,             // apb ready
	output var  logic                  pslverr,            // apb error, unmapped address
	output var  logic                  allowFwd,           // forward motion permitted
	output var  logic                  allowRev,           // reverse motion permitted
	output var  logic                  motorPowered,       // motor power stage on
	output var  logic                  brakeActive,        // braking torque stop in progress
	output var  logic [TRQ_W-1:0]      brakeTorque,        // active braking torque limit, percent
	output var  logic                  zeroClamp,          // position loop held at zero command
	output var  logic                  posClearReq         // position error clear awaited
);
	generate
		if (NUM_INPUTS < 4 || NUM_INPUTS > 8) begin : g_bad_inputs
			$error("NUM_INPUTS must lie between 4 and 8");
		end
	endgenerate

	logic [NUM_INPUTS-1:0] genSync;
	ot_cfg_s               pendCfg_q, pendCfg_d;
	ot_cfg_s               actCfg_q, actCfg_d;
	logic [TRQ_W-1:0]      trq_q, trq_d;
	ot_state_e             state_q, state_d;
	logic                  servoPrev_q;
	logic                  clrPend_q, clrPend_d;
	logic                  otFwd;
	logic                  otRev;
	logic                  trigger;
	logic                  useBrake;
	logic                  clampAfter;
	logic                  servoRise;
	logic                  busWrite;
	logic                  busSetup;
	logic                  mapped;
	logic [31:0]           rdMux;
	logic [TRQ_W-1:0]      wrTrq;

	sync_2ff #(
		.WIDTH(NUM_INPUTS)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.d  (genIn),
		.q  (genSync)
	);

	function automatic logic pickInput(input logic [3:0] sel, input logic [NUM_INPUTS-1:0] v);
		logic r;
		r = 1'b0;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			if (int'(sel) == i + 1) begin
				r = v[i];
			end
		end
		return r;
	endfunction

	// selector 9 matches no input, so the limit reads inactive
	assign otFwd = pickInput(actCfg_q.fwdSel, genSync);
	assign otRev = pickInput(actCfg_q.revSel, genSync);
	// only the blocked direction trips a stop
	assign trigger = (otFwd & cmdFwd) | (otRev & cmdRev);

	// clamp wins over the low digit; coast codes skip the braking phase
	assign clampAfter = (actCfg_q.highSel == HIGH_CLAMP);
	assign useBrake   = clampAfter || (actCfg_q.highSel != HIGH_COAST && actCfg_q.lowSel != LOW_COAST);
	assign servoRise  = servoOn & ~servoPrev_q;

	// stop sequencer
	always_comb begin
		state_d   = state_q;
		clrPend_d = clrPend_q & ~positionErrorClear;
		case (state_q)
			ST_RUN: begin
				if (trigger) begin
					// coast codes go straight to coast
					state_d = useBrake ? ST_BRAKE : ST_COAST;
				end
			end
			ST_BRAKE: begin
				if (standstill) begin
					state_d = clampAfter ? ST_CLAMP : ST_COAST;
				end
			end
			ST_COAST: begin
				if (servoRise) begin
					state_d = ST_RUN;
				end
			end
			ST_CLAMP: begin
				if (!trigger && (cmdFwd || cmdRev)) begin
					state_d = ST_RUN;
				end
			end
			default: begin
				state_d = ST_RUN;
			end
		endcase
		// request stands until the host clears; a new stop wins
		if (state_q == ST_RUN && state_d != ST_RUN && ctrlMode == MODE_POSITION) begin
			clrPend_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q      <= ST_RUN;
			clrPend_q    <= 1'b0;
			servoPrev_q  <= 1'b0;
			allowFwd     <= 1'b1;
			allowRev     <= 1'b1;
			motorPowered <= 1'b1;
			brakeActive  <= 1'b0;
			zeroClamp    <= 1'b0;
			brakeTorque  <= '0;
			posClearReq  <= 1'b0;
		end else begin
			state_q      <= state_d;
			clrPend_q    <= clrPend_d;
			servoPrev_q  <= servoOn;
			allowFwd     <= ~otFwd;
			allowRev     <= ~otRev;
			motorPowered <= (state_d != ST_COAST);
			brakeActive  <= (state_d == ST_BRAKE);
			zeroClamp    <= (state_d == ST_CLAMP);
			// next torque value, so a limit written during braking shows in step with trq_q
			brakeTorque  <= (state_d == ST_BRAKE) ? trq_d : '0;
			posClearReq  <= clrPend_d;
		end
	end

	// register file, zero wait: answer in the access cycle
	assign busSetup = psel & ~penable;
	assign busWrite = psel & penable & pready & pwrite & ~pslverr;
	assign mapped   = (paddr == OFS_INPUT_ASSIGN) || (paddr == OFS_STOP_SELECT) ||
		(paddr == OFS_BRAKE_TORQUE) || (paddr == OFS_STATUS);
	assign wrTrq = (pwdata[TRQ_W-1:0] > TORQUE_MAX || pwdata[31:TRQ_W] != '0) ? TORQUE_MAX : pwdata[TRQ_W-1:0];

	always_comb begin
		pendCfg_d = pendCfg_q;
		actCfg_d  = actCfg_q;
		trq_d     = trq_q;
		if (busWrite && paddr == OFS_INPUT_ASSIGN) begin
			pendCfg_d.fwdSel = pwdata[FLD_LOW_LSB +: FLD_W];
			pendCfg_d.revSel = pwdata[FLD_HIGH_LSB +: FLD_W];
		end
		if (busWrite && paddr == OFS_STOP_SELECT) begin
			pendCfg_d.lowSel  = pwdata[FLD_LOW_LSB +: FLD_W];
			pendCfg_d.highSel = pwdata[FLD_HIGH_LSB +: FLD_W];
		end
		if (busWrite && paddr == OFS_BRAKE_TORQUE) begin
			trq_d = wrTrq;
		end
		// active copy only moves at restart
		if (powerCycle) begin
			actCfg_d = pendCfg_q;
		end
	end

	always_comb begin
		rdMux = '0;
		case (paddr)
			OFS_INPUT_ASSIGN: begin
				rdMux[FLD_LOW_LSB +: FLD_W]  = pendCfg_q.fwdSel;
				rdMux[FLD_HIGH_LSB +: FLD_W] = pendCfg_q.revSel;
			end
			OFS_STOP_SELECT: begin
				rdMux[FLD_LOW_LSB +: FLD_W]  = pendCfg_q.lowSel;
				rdMux[FLD_HIGH_LSB +: FLD_W] = pendCfg_q.highSel;
			end
			OFS_BRAKE_TORQUE: begin
				rdMux[TRQ_W-1:0] = trq_q;
			end
			OFS_STATUS: begin
				rdMux[ST_OT_FWD_BIT]        = otFwd;
				rdMux[ST_OT_REV_BIT]        = otRev;
				rdMux[ST_STATE_LSB +: $bits(ot_state_e)] = state_q;
				rdMux[ST_CLR_BIT]           = clrPend_q;
				rdMux[ST_PWR_BIT]           = motorPowered;
				rdMux[FLD_LOW_LSB +: FLD_W] = actCfg_q.lowSel;
				rdMux[FLD_HIGH_LSB +: FLD_W] = actCfg_q.highSel;
			end
			default: begin
				rdMux = '0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pendCfg_q <= CFG_RESET;
			actCfg_q  <= CFG_RESET;
			trq_q     <= TORQUE_MAX;
			prdata    <= '0;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
		end else begin
			pendCfg_q <= pendCfg_d;
			actCfg_q  <= actCfg_d;
			trq_q     <= trq_d;
			prdata    <= busSetup ? rdMux : '0;
			pready    <= busSetup;
			pslverr   <= busSetup & ~mapped;
		end
	end

	property p_fwd_block;
		@(posedge clk) disable iff (rst) otFwd |=> !allowFwd;
	endproperty
	a_fwd_block: assert property (p_fwd_block) else $error("forward allowed in forward over-travel");

	property p_rev_block;
		@(posedge clk) disable iff (rst) otRev |=> !allowRev;
	endproperty
	a_rev_block: assert property (p_rev_block) else $error("reverse allowed in reverse over-travel");

	property p_opposite;
		@(posedge clk) disable iff (rst) (otFwd && !otRev) |=> allowRev;
	endproperty
	a_opposite: assert property (p_opposite) else $error("reverse blocked by forward over-travel");

	property p_fwd_ignore;
		@(posedge clk) disable iff (rst) (actCfg_q.fwdSel == SEL_IGNORE) |=> allowFwd;
	endproperty
	a_fwd_ignore: assert property (p_fwd_ignore) else $error("ignored forward limit still blocks");

	property p_rev_ignore;
		@(posedge clk) disable iff (rst) (actCfg_q.revSel == SEL_IGNORE) |=> allowRev;
	endproperty
	a_rev_ignore: assert property (p_rev_ignore) else $error("ignored reverse limit still blocks");

	property p_cfg_hold;
		@(posedge clk) disable iff (rst) !powerCycle |=> $stable(actCfg_q);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("active settings changed without restart");

	property p_brake_coast;
		@(posedge clk) disable iff (rst) (state_q == ST_BRAKE && standstill && !clampAfter)
			|=> (state_q == ST_COAST && !motorPowered && !brakeActive);
	endproperty
	a_brake_coast: assert property (p_brake_coast) else $error("no coast after braking stop");

	property p_coast_stop;
		@(posedge clk) disable iff (rst) (state_q == ST_RUN && trigger && !useBrake)
			|=> !motorPowered ##1 (!motorPowered || $past(servoRise));
	endproperty
	a_coast_stop: assert property (p_coast_stop) else $error("coast stop left power on");

	property p_clamp;
		@(posedge clk) disable iff (rst) (state_q == ST_BRAKE && standstill && clampAfter)
			|=> zeroClamp && motorPowered && brakeTorque == '0;
	endproperty
	a_clamp: assert property (p_clamp) else $error("no zero clamp after braking stop");

	property p_resume;
		@(posedge clk) disable iff (rst) (state_q == ST_COAST && servoRise) |=> motorPowered;
	endproperty
	a_resume: assert property (p_resume) else $error("servo on did not resume control");

	property p_torque;
		@(posedge clk) disable iff (rst) brakeActive |-> (brakeTorque == trq_q && trq_q <= TORQUE_MAX);
	endproperty
	a_torque: assert property (p_torque) else $error("braking torque wrong or above ceiling");

endmodule
`default_nettype wire

//--- sim/limit_switch_model.sv
// far-side model: two limit switches wired onto the general inputs
`default_nettype none
module limit_switch_model (
	input  wire logic       fwdHit, // forward switch opened
	input  wire logic       revHit, // reverse switch opened
	input  wire logic [7:0] noise,  // activity on unrelated inputs
	output var  logic [7:0] genIn   // general input levels
);
	timeunit 1ns;
	timeprecision 1ps;
	// an opened switch reads high; unused inputs keep toggling so stray selects show up
	always_comb begin
		genIn = noise;
		genIn[2] = fwdHit;
		genIn[3] = revHit;
	end
endmodule
`default_nettype wire

//--- sim/overtravel_limit_stop_logic_tb.sv
// self-checking bench for the over-travel stop logic
`default_nettype none
module overtravel_limit_stop_logic_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import otl_pkg::*;
	logic        clk, rst, cmdFwd, cmdRev, standstill, servoOn, positionErrorClear, powerCycle;
	logic        psel, penable, pwrite, pready, pslverr, fwdHit, revHit;
	logic        allowFwd, allowRev, motorPowered, brakeActive, zeroClamp, posClearReq;
	logic [7:0]  paddr, noise, genIn;
	logic [31:0] pwdata, prdata, seed;
	logic [8:0]  brakeTorque;
	ctrl_mode_e  ctrlMode;
	logic [32:0] expQ[$];
	int          nErrors, numChecks;
	overtravel_limit_stop_logic uut (.clk(clk), .rst(rst), .genIn(genIn), .cmdFwd(cmdFwd), .cmdRev(cmdRev),
		.standstill(standstill), .servoOn(servoOn), .ctrlMode(ctrlMode), .positionErrorClear(positionErrorClear),
		.powerCycle(powerCycle), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .allowFwd(allowFwd), .allowRev(allowRev),
		.motorPowered(motorPowered), .brakeActive(brakeActive), .brakeTorque(brakeTorque),
		.zeroClamp(zeroClamp), .posClearReq(posClearReq));
	limit_switch_model sw (.fwdHit(fwdHit), .revHit(revHit), .noise(noise), .genIn(genIn));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [32:0] seen, input logic [32:0] want);
		numChecks++;
		if (seen !== want) begin
			nErrors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic finalReport();
		$display("checks %0d errors %0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one apb transfer; a read notes its expected {pslverr, prdata} for the monitor
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) expQ.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		// no wait count assumed: only the watchdog ends a hung transfer
		do begin
			@(posedge clk);
		end while (!pready);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, {1'b0, e});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0_0000_0000);
	endtask
	// settings only move to the active copy on a restart pulse
	task automatic restart();
		powerCycle <= 1'b1;
		wt(1);
		powerCycle <= 1'b0;
		wt(1);
	endtask
	always @(posedge clk) begin
		seed <= lfsr(seed);
		noise <= seed[7:0];
		if (psel && penable && pready && !pwrite) begin
			if (expQ.size() == 0) chk({pslverr, prdata}, 33'h1_ffff_ffff);
			else chk({pslverr, prdata}, expQ.pop_front());
		end
	end
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#100000;
		nErrors++;
		finalReport();
	end
	initial begin
		{rst, cmdFwd, cmdRev, standstill, servoOn, positionErrorClear, powerCycle} = 7'h7f & 7'h40;
		{psel, penable, pwrite, fwdHit, revHit} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		seed = 32'h0000_354c;
		noise = 8'h00;
		ctrlMode = MODE_POSITION;
		wt(4);
		rst <= 1'b0;
		rd(OFS_INPUT_ASSIGN, {16'h0000, REV_SEL_RESET, FWD_SEL_RESET, 8'h00});
		rd(OFS_STOP_SELECT, 32'h0000_0000);
		rd(OFS_BRAKE_TORQUE, {23'h00_0000, TORQUE_MAX});
		rd(OFS_STATUS, 32'h0000_0020);
		apb(1'b0, 8'h10, 32'h0000_0000, 33'h1_0000_0000);
		wr(OFS_BRAKE_TORQUE, 32'h0000_0190);
		rd(OFS_BRAKE_TORQUE, {23'h00_0000, TORQUE_MAX});
		wr(OFS_BRAKE_TORQUE, 32'h0000_0032);
		rd(OFS_BRAKE_TORQUE, 32'h0000_0032);
		// three edges through synchroniser and output flop, sampled one edge later
		fwdHit <= 1'b1;
		wt(4);
		chk(allowFwd, 1'b0);
		chk(allowRev, 1'b1);
		rd(OFS_STATUS, 32'h0000_0021);
		cmdFwd <= 1'b1;
		wt(2);
		chk(brakeActive, 1'b1);
		chk({24'h00_0000, brakeTorque}, 33'h0_0000_0032);
		cmdFwd <= 1'b0;
		standstill <= 1'b1;
		wt(2);
		chk({brakeActive, motorPowered, posClearReq}, 3'h1);
		// host discards the position offset before resuming
		positionErrorClear <= 1'b1;
		wt(1);
		positionErrorClear <= 1'b0;
		wt(2);
		chk(posClearReq, 1'b0);
		servoOn <= 1'b1;
		wt(2);
		chk(motorPowered, 1'b1);
		{servoOn, standstill, fwdHit} <= 3'h0;
		revHit <= 1'b1;
		wt(4);
		chk({allowFwd, allowRev}, 2'h2);
		// host picks the clamping stop, as for a vertical axis
		wr(OFS_STOP_SELECT, 32'h0000_1000);
		rd(OFS_STATUS, 32'h0000_0022);
		rd(OFS_STOP_SELECT, 32'h0000_1000);
		restart();
		rd(OFS_STATUS, 32'h0000_1022);
		ctrlMode <= MODE_TORQUE;
		cmdRev <= 1'b1;
		wt(2);
		chk(brakeActive, 1'b1);
		cmdRev <= 1'b0;
		standstill <= 1'b1;
		wt(2);
		chk({zeroClamp, motorPowered, brakeActive}, 3'h6);
		cmdFwd <= 1'b1;
		wt(2);
		chk(zeroClamp, 1'b0);
		{cmdFwd, standstill} <= 2'h0;
		ctrlMode <= MODE_SPEED;
		for (int i = 0; i < 2; i++) begin
			wr(OFS_STOP_SELECT, i == 0 ? 32'h0000_0100 : 32'h0000_2000);
			restart();
			cmdRev <= 1'b1;
			wt(2);
			chk({motorPowered, brakeActive}, 2'h0);
			cmdRev <= 1'b0;
			wt(3);
			chk(motorPowered, 1'b0);
			servoOn <= 1'b1;
			wt(2);
			chk(motorPowered, 1'b1);
			servoOn <= 1'b0;
		end
		wr(OFS_INPUT_ASSIGN, 32'h0000_9900);
		restart();
		fwdHit <= 1'b1;
		wt(4);
		chk({allowFwd, allowRev}, 2'h3);
		wt(2);
		finalReport();
	end
endmodule
`default_nettype wire
